/* File: core/qicc_pkg.sv */
package qicc_pkg;
    localparam logic [19:0] ADDR_DQ_HIGH = 20'h70010;
    localparam logic [19:0] ADDR_DQ_LOW = 20'h70014;
    localparam logic [19:0] ADDR_EQ_HIGH = 20'h70018;
    localparam logic [19:0] ADDR_EQ_LOW = 20'h7001c;
    localparam logic [19:0] ADDR_ID_MASK = 20'h70020;
    localparam logic [19:0] ADDR_ID_BASE = 20'h70024;
    localparam logic [19:0] ADDR_CTRL = 20'h70028;
    localparam logic [19:0] ADDR_DESC0 = 20'h70100;

    localparam int SUBPORTALS = 4;
    localparam int SP_W = 2;
    localparam int THR_LSB = 24;
    localparam int DEQUEUE_BYTE_LIMIT_LSB = 0;
    localparam int SRC_LSB = 8;
    localparam int DEQUEUE_FRAME_COUNT_SELECT_BIT = 4;
    localparam int VERB_LSB = 0;
    localparam int MASK_LSB = 16;
    localparam int NSB_LSB = 16;
    localparam int SB_LSB = 0;
    localparam int ID_USE = 8;

    localparam logic [31:0] DQ_HIGH_RST = 32'h0000ffff;
    localparam logic [31:0] DQ_LOW_RST = 32'h00000000;
    localparam logic [31:0] EQ_HIGH_RST = 32'h00000003;
    localparam logic [31:0] EQ_LOW_RST = 32'h00000000;
    localparam logic [31:0] ID_MASK_RST = 32'h03ff0000;
    localparam logic [31:0] ID_BASE_RST = 32'h00000000;
    // verb bit that marks an unscheduled dequeue
    localparam int VERB_UNSCHED_BIT = 3;
    localparam logic [3:0] OVR_CODE = 4'hf;

    typedef struct packed {
        logic [SP_W-1:0] subportal;
        logic [23:0] source;
        logic [15:0] byte_count;
        logic frame_count_sel;
        logic [3:0] verb;
    } qicc_dq_cmd_t;

    typedef struct packed {
        logic [1:0] color;
        logic [31:0] tag;
    } qicc_eq_cmd_t;

    typedef struct packed {
        logic [11:0] frame_id;
        logic [3:0] status_code;
        logic [11:0] override_id;
    } qicc_job_t;

    typedef struct packed {
        logic [11:0] seq_id;
        logic [11:0] nonseq_id;
    } qicc_ids_t;
endpackage

/* File: core/qicc_id_calc.sv */
`timescale 1ns/1ns
module qicc_id_calc (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic job_valid_in,
    input wire qicc_pkg::qicc_job_t job_in,
    input wire logic [7:0] mask_in,
    input wire logic [7:0] nonseq_base_in,
    input wire logic [7:0] seq_base_in,
    output qicc_pkg::qicc_ids_t ids_out,
    output logic valid_out
);
    wire logic [11:0] masked_id = {4'h0, job_in.frame_id[7:0] & mask_in};
    wire logic [11:0] nonseq_calc = masked_id + {4'h0, nonseq_base_in};
    wire logic [11:0] seq_calc = job_in.frame_id + {4'h0, seq_base_in};
    wire logic use_override = job_in.status_code == qicc_pkg::OVR_CODE;
    wire logic [11:0] nonseq_sel = use_override ? job_in.override_id : nonseq_calc;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ids_out <= '0;
            valid_out <= 1'b0;
        end else begin
            valid_out <= job_valid_in;
            if (job_valid_in) begin
                ids_out <= '{seq_id: seq_calc, nonseq_id: nonseq_sel};
            end
        end
    end
endmodule

/* File: core/qicc_top.sv */
`timescale 1ns/1ns
module qicc_top (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [19:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic frames_avail_in,
    input wire logic dq_ready_in,
    output qicc_pkg::qicc_dq_cmd_t dq_cmd_out,
    output logic dq_valid_out,
    input wire logic [qicc_pkg::SUBPORTALS-1:0] frame_done_in,
    input wire logic eq_req_in,
    output qicc_pkg::qicc_eq_cmd_t eq_cmd_out,
    output logic eq_valid_out,
    input wire logic job_valid_in,
    input wire qicc_pkg::qicc_job_t job_in,
    output qicc_pkg::qicc_ids_t qi_ids_out,
    output qicc_pkg::qicc_ids_t descriptor_controller_ids_out,
    output logic ids_valid_out,
    input wire logic seq_cmd_in,
    output logic [11:0] mem_id_out,
    input wire logic xfer_pending_in,
    input wire logic [31:0] desc_first_word_in
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [31:0] dq_high_q;
    logic [31:0] dq_low_q;
    logic [31:0] eq_high_q;
    logic [31:0] eq_low_q;
    logic [31:0] id_mask_q;
    logic [31:0] id_base_q;
    logic enable_q;

    wire logic hit_dqh = addr_in == qicc_pkg::ADDR_DQ_HIGH;
    wire logic hit_dql = addr_in == qicc_pkg::ADDR_DQ_LOW;
    wire logic hit_eqh = addr_in == qicc_pkg::ADDR_EQ_HIGH;
    wire logic hit_eql = addr_in == qicc_pkg::ADDR_EQ_LOW;
    wire logic hit_msk = addr_in == qicc_pkg::ADDR_ID_MASK;
    wire logic hit_bas = addr_in == qicc_pkg::ADDR_ID_BASE;
    wire logic hit_ctl = addr_in == qicc_pkg::ADDR_CTRL;
    wire logic hit_dsc = addr_in == qicc_pkg::ADDR_DESC0;

    // reserved bits forced to zero on write
    wire logic [31:0] dqh_wmask = 32'h0700ffff;
    wire logic [31:0] dql_wmask = 32'hffffff1f;
    wire logic [31:0] eqh_wmask = 32'h00000003;
    wire logic [31:0] msk_wmask = 32'h03ff0000;
    wire logic [31:0] bas_wmask = 32'h0fff0fff;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            dq_high_q <= qicc_pkg::DQ_HIGH_RST;
            dq_low_q <= qicc_pkg::DQ_LOW_RST;
            eq_high_q <= qicc_pkg::EQ_HIGH_RST;
            eq_low_q <= qicc_pkg::EQ_LOW_RST;
            id_mask_q <= qicc_pkg::ID_MASK_RST;
            id_base_q <= qicc_pkg::ID_BASE_RST;
            enable_q <= 1'b0;
        end else if (wr_in) begin
            // each 64-bit register as two words
            if (hit_dqh) dq_high_q <= wdata_in & dqh_wmask;
            if (hit_dql) dq_low_q <= wdata_in & dql_wmask;
            if (hit_eqh) eq_high_q <= wdata_in & eqh_wmask;
            if (hit_eql) eq_low_q <= wdata_in;
            if (hit_msk) id_mask_q <= wdata_in & msk_wmask;
            if (hit_bas) id_base_q <= wdata_in & bas_wmask;
            if (hit_ctl) enable_q <= wdata_in[0];
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    wire logic [31:0] desc_view = xfer_pending_in ? desc_first_word_in : 32'h00000000;
    wire logic [31:0] rd_mux =
        hit_dqh ? dq_high_q :
        hit_dql ? dq_low_q :
        hit_eqh ? eq_high_q :
        hit_eql ? eq_low_q :
        hit_msk ? id_mask_q :
        hit_bas ? id_base_q :
        hit_ctl ? {31'h0, enable_q} :
        hit_dsc ? desc_view : 32'h00000000;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= rd_in ? rd_mux : 32'h00000000;
        end
    end

    // ************************************************************
    // dequeue issue
    // ************************************************************
    wire logic [2:0] threshold = dq_high_q[qicc_pkg::THR_LSB +: 3];
    logic [2:0] inflight_q [qicc_pkg::SUBPORTALS];
    logic [qicc_pkg::SP_W-1:0] sp_q;
    wire logic [qicc_pkg::SUBPORTALS-1:0] sp_ok;
    wire logic dq_fire = dq_valid_out && dq_ready_in;

    genvar gi;
    generate
        for (gi = 0; gi < qicc_pkg::SUBPORTALS; gi++) begin : g_sp
            wire logic inc = dq_fire && int'(dq_cmd_out.subportal) == gi;
            wire logic dec = frame_done_in[gi] && inflight_q[gi] != 3'h0;
            assign sp_ok[gi] = inflight_q[gi] < threshold;
            always_ff @(posedge mclk_in or posedge reset_in) begin
                if (reset_in) begin
                    inflight_q[gi] <= 3'h0;
                end else if (inc && !dec) begin
                    inflight_q[gi] <= inflight_q[gi] + 3'h1;
                end else if (dec && !inc) begin
                    inflight_q[gi] <= inflight_q[gi] - 3'h1;
                end
            end
        end
    endgenerate

    wire logic [3:0] verb_cfg = dq_low_q[qicc_pkg::VERB_LSB +: 4];
    // unscheduled-dequeue bit always forced clear
    wire logic [3:0] verb_safe = verb_cfg & ~(4'h1 << qicc_pkg::VERB_UNSCHED_BIT);
    wire logic can_issue = enable_q && frames_avail_in && sp_ok[sp_q];
    wire logic load_cmd = can_issue && (!dq_valid_out || dq_fire);

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            dq_cmd_out <= '0;
            dq_valid_out <= 1'b0;
            sp_q <= '0;
        end else begin
            if (load_cmd) begin
                // fields sampled as the command forms
                dq_cmd_out.subportal <= sp_q;
                dq_cmd_out.byte_count <= dq_high_q[qicc_pkg::DEQUEUE_BYTE_LIMIT_LSB +: 16];
                dq_cmd_out.source <= dq_low_q[qicc_pkg::SRC_LSB +: 24];
                dq_cmd_out.frame_count_sel <= dq_low_q[qicc_pkg::DEQUEUE_FRAME_COUNT_SELECT_BIT];
                dq_cmd_out.verb <= verb_safe;
                dq_valid_out <= 1'b1;
            end else if (dq_fire) begin
                dq_valid_out <= 1'b0;
            end
            // rotate subportals after each issue or when current one blocked
            if (load_cmd || !sp_ok[sp_q]) begin
                sp_q <= sp_q + 1'b1;
            end
        end
    end

    // ************************************************************
    // enqueue command
    // ************************************************************
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            eq_cmd_out <= '0;
            eq_valid_out <= 1'b0;
        end else begin
            eq_valid_out <= eq_req_in;
            if (eq_req_in) begin
                eq_cmd_out.color <= eq_high_q[1:0];
                eq_cmd_out.tag <= eq_low_q;
            end
        end
    end

    // ************************************************************
    // isolation ids
    // ************************************************************
    qicc_pkg::qicc_ids_t ids_w;
    logic ids_v_w;

    qicc_id_calc u_id (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .job_valid_in(job_valid_in),
        .job_in(job_in),
        .mask_in(id_mask_q[qicc_pkg::MASK_LSB +: qicc_pkg::ID_USE]),
        .nonseq_base_in(id_base_q[qicc_pkg::NSB_LSB +: qicc_pkg::ID_USE]),
        .seq_base_in(id_base_q[qicc_pkg::SB_LSB +: qicc_pkg::ID_USE]),
        .ids_out(ids_w),
        .valid_out(ids_v_w)
    );

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            qi_ids_out <= '0;
            descriptor_controller_ids_out <= '0;
            ids_valid_out <= 1'b0;
            mem_id_out <= '0;
        end else begin
            ids_valid_out <= ids_v_w;
            if (ids_v_w) begin
                qi_ids_out <= ids_w;
                descriptor_controller_ids_out <= ids_w;
            end
            mem_id_out <= seq_cmd_in ? qi_ids_out.seq_id : qi_ids_out.nonseq_id;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    sequence s_job_in;
        job_valid_in && job_in.status_code != qicc_pkg::OVR_CODE;
    endsequence

    thr_zero_a: assert property (threshold == 3'h0 |=> !$rose(dq_valid_out))
        else $error("dequeue issued with zero threshold");
    enable_gate_a: assert property (!enable_q |=> !$rose(dq_valid_out))
        else $error("dequeue issued while disabled");
    no_unsched_a: assert property (dq_valid_out |-> !dq_cmd_out.verb[qicc_pkg::VERB_UNSCHED_BIT])
        else $error("unscheduled verb issued");
    byte_cnt_a: assert property (load_cmd |=> dq_cmd_out.byte_count == $past(dq_high_q[15:0]))
        else $error("byte count mismatch");
    eq_color_a: assert property (eq_req_in |=> eq_valid_out && eq_cmd_out.color == $past(eq_high_q[1:0]))
        else $error("enqueue color mismatch");
    nonseq_id_a: assert property (s_job_in |-> ##2 ids_valid_out && qi_ids_out.nonseq_id ==
        ({4'h0, $past(job_in.frame_id[7:0] & id_mask_q[23:16], 2)} + {4'h0, $past(id_base_q[23:16], 2)}))
        else $error("non-sequence id wrong");
    seq_id_a: assert property (job_valid_in |-> ##2 qi_ids_out.seq_id ==
        $past(job_in.frame_id, 2) + {4'h0, $past(id_base_q[7:0], 2)})
        else $error("sequence id wrong");
    desc_zero_a: assert property (rd_in && hit_dsc && !xfer_pending_in |=> rdata_out == 32'h0)
        else $error("debug word not zero");
    ids_pair_a: assert property (ids_valid_out |-> descriptor_controller_ids_out == qi_ids_out)
        else $error("id copies differ");
endmodule

/* File: verification/qicc_qm_model.sv */
`timescale 1ns/1ns
// ****************************************
// queue manager stand-in
// ****************************************
module qicc_qm_model (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic avail_in,
    input wire logic slow_in,
    output logic frames_avail_out,
    output logic dq_ready_out
);
    logic phase_q;
    // frames offered whenever any are queued
    assign frames_avail_out = avail_in;
    // slow mode accepts a command every other cycle
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end
    assign dq_ready_out = ~slow_in | phase_q;
endmodule

/* File: verification/qicc_top_bench.sv */
`timescale 1ns/1ns
module qicc_top_bench;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [19:0] addr_in = 20'h00000;
    logic [31:0] wdata_in = 32'h00000000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic avail = 1'b0;
    logic slow = 1'b0;
    logic [qicc_pkg::SUBPORTALS-1:0] frame_done_in = 4'h0;
    logic eq_req_in = 1'b0;
    logic job_valid_in = 1'b0;
    qicc_pkg::qicc_job_t job_in = 28'h0000000;
    logic seq_cmd_in = 1'b0;
    logic xfer_pending_in = 1'b0;
    logic [31:0] desc_first_word_in = 32'h00000000;
    logic [31:0] rdata_out;
    logic frames_avail_in, dq_ready_in, dq_valid_out, eq_valid_out, ids_valid_out;
    qicc_pkg::qicc_dq_cmd_t dq_cmd_out;
    qicc_pkg::qicc_eq_cmd_t eq_cmd_out;
    qicc_pkg::qicc_ids_t qi_ids_out, descriptor_controller_ids_out;
    logic [11:0] mem_id_out;
    int bad_count = 0;
    int comparisons = 0;

    always #5 mclk_in = ~mclk_in;

    qicc_top u_qicc_top (
        .mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .frames_avail_in(frames_avail_in),
        .dq_ready_in(dq_ready_in), .dq_cmd_out(dq_cmd_out), .dq_valid_out(dq_valid_out),
        .frame_done_in(frame_done_in), .eq_req_in(eq_req_in), .eq_cmd_out(eq_cmd_out),
        .eq_valid_out(eq_valid_out), .job_valid_in(job_valid_in), .job_in(job_in),
        .qi_ids_out(qi_ids_out), .descriptor_controller_ids_out(descriptor_controller_ids_out), .ids_valid_out(ids_valid_out),
        .seq_cmd_in(seq_cmd_in), .mem_id_out(mem_id_out), .xfer_pending_in(xfer_pending_in),
        .desc_first_word_in(desc_first_word_in)
    );
    qicc_qm_model u_qicc_qm_model (.mclk_in(mclk_in), .reset_in(reset_in), .avail_in(avail),
        .slow_in(slow), .frames_avail_out(frames_avail_in), .dq_ready_out(dq_ready_in));

    // ****************************************
    // shared tasks
    // ****************************************
    task results;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    task rd(input logic [19:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    task reg_chk(input logic [19:0] a, input logic [31:0] rst, input logic [31:0] msk,
            input logic [31:0] wide);
        logic [31:0] v;
        rd(a, v);
        chk(v & msk, rst & msk);
        wr(a, 32'hffffffff);
        rd(a, v);
        chk(v & msk, msk);
        chk(v & ~wide, 32'h00000000);
        wr(a, rst);
    endtask

    task dq_expect(input logic [1:0] sp, input logic [31:0] hi, input logic [31:0] lo);
        int i;
        for (i = 0; i < 60; i++) begin
            @(posedge mclk_in);
            if (dq_valid_out === 1'b1 && dq_ready_in === 1'b1) begin
                chk(32'(dq_cmd_out.subportal), 32'(sp));
                chk(32'(dq_cmd_out.byte_count), 32'(hi[15:0]));
                chk(32'(dq_cmd_out.source), 32'(lo[31:8]));
                chk(32'(dq_cmd_out.frame_count_sel), 32'(lo[4]));
                chk(32'(dq_cmd_out.verb), 32'(lo[3:0] & 4'h7));
                return;
            end
        end
        bad_count++;
        $display("ERROR %0t: dequeue command missing", $time);
        results();
    endtask

    task dq_none;
        logic seen;
        int i;
        seen = 1'b0;
        for (i = 0; i < 30; i++) begin
            @(posedge mclk_in);
            seen = seen | (dq_valid_out !== 1'b0);
        end
        chk(32'(seen), 32'h00000000);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        logic [31:0] v;
        reg_chk(20'h70010, 32'h0000ffff, 32'h0700ffff, 32'h0700ffff);
        reg_chk(20'h70014, 32'h00000000, 32'hffffff1f, 32'hffffff1f);
        reg_chk(20'h70018, 32'h00000003, 32'h00000003, 32'h00000003);
        reg_chk(20'h7001c, 32'h00000000, 32'hffffffff, 32'hffffffff);
        reg_chk(20'h70020, 32'h03ff0000, 32'h00ff0000, 32'h03ff0000);
        reg_chk(20'h70024, 32'h00000000, 32'h00ff00ff, 32'h0fff0fff);
        reg_chk(20'h70028, 32'h00000000, 32'h00000001, 32'h00000001);
        rd(20'h70030, v);
        chk(v, 32'h00000000);
    endtask

    task t_desc;
        logic [31:0] v;
        desc_first_word_in <= 32'hc0de1234;
        wr(20'h70100, 32'hffffffff);
        rd(20'h70100, v);
        chk(v, 32'h00000000);
        xfer_pending_in <= 1'b1;
        rd(20'h70100, v);
        chk(v, 32'hc0de1234);
        xfer_pending_in <= 1'b0;
    endtask

    task t_deq;
        int i;
        avail <= 1'b1;
        wr(20'h70010, 32'h00001234);
        wr(20'h70014, 32'h5a5a5a19);
        wr(20'h70028, 32'h00000001);
        dq_none();
        wr(20'h70028, 32'h00000000);
        wr(20'h70010, 32'h02001234);
        dq_none();
        avail <= 1'b0;
        wr(20'h70028, 32'h00000001);
        dq_none();
        slow <= 1'b1;
        avail <= 1'b1;
        for (i = 0; i < 8; i++) begin
            dq_expect(i[1:0], 32'h02001234, 32'h5a5a5a19);
        end
        dq_none();
        wr(20'h70010, 32'h02000040);
        wr(20'h70014, 32'h00abcd02);
        @(posedge mclk_in);
        frame_done_in <= 4'h4;
        @(posedge mclk_in);
        frame_done_in <= 4'h0;
        dq_expect(2'h2, 32'h02000040, 32'h00abcd02);
        dq_none();
        wr(20'h70028, 32'h00000000);
        slow <= 1'b0;
    endtask

    task eq_one(input logic [1:0] col, input logic [31:0] tag);
        wr(20'h70018, {30'h00000000, col});
        wr(20'h7001c, tag);
        @(posedge mclk_in);
        eq_req_in <= 1'b1;
        @(posedge mclk_in);
        eq_req_in <= 1'b0;
        #1;
        chk(32'(eq_valid_out), 32'h00000001);
        chk(32'(eq_cmd_out.color), 32'(col));
        chk(eq_cmd_out.tag, tag);
    endtask

    task id_one(input logic [27:0] job, input logic [11:0] sq, input logic [11:0] ns);
        @(posedge mclk_in);
        job_valid_in <= 1'b1;
        job_in <= job;
        @(posedge mclk_in);
        job_valid_in <= 1'b0;
        @(posedge mclk_in);
        #1;
        chk(32'(ids_valid_out), 32'h00000001);
        chk(32'(qi_ids_out), 32'({sq, ns}));
        chk(32'(descriptor_controller_ids_out), 32'({sq, ns}));
        seq_cmd_in <= 1'b1;
        @(posedge mclk_in);
        #1 chk(32'(mem_id_out), 32'(sq));
        seq_cmd_in <= 1'b0;
        @(posedge mclk_in);
        #1 chk(32'(mem_id_out), 32'(ns));
    endtask

    initial begin
        repeat (4) @(posedge mclk_in);
        reset_in <= 1'b0;
        t_regs();
        t_desc();
        t_deq();
        eq_one(2'h2, 32'ha5c31e0f);
        eq_one(2'h1, 32'h3c5a0f96);
        wr(20'h70020, 32'h030f0000);
        wr(20'h70024, 32'h01200131);
        id_one({12'h3ab, 4'h0, 12'h555}, 12'h3dc, 12'h02b);
        id_one({12'h0f7, 4'hf, 12'h123}, 12'h128, 12'h123);
        results();
    end
endmodule
